// ===== tws_channel.sv
// The Avalon-MM register port was decided locally.
`include "tws_regs.svh"
// Overview of operation
// R1: Gap enable bit set makes the 5-bit gap count time inter-byte gaps.
// R2: Least gap is (n+1)*64 plus 28 system clocks plus half serial clock.
// R3: Longest gap is (n+1)*64 plus 36 system clocks plus 1.5 serial clocks.
// R4: Gap never shorter than two serial clock periods.
// R5: Software leaves the gap register alone during automatic transfer.
// R6: Software writes zero to gap register bits 5 and 6.
// R7: With gap control active, busy input is ignored.
// R8: Stop mode: no shifting, shift register is a plain 8-bit register.
// R9: Stop mode: serial, strobe and busy pins return to port function.
// R10: Channel disabled stops shifting and clears bit counter; enabled counts edges.
// R11: Clock source bit: 0 takes partner clock, 1 drives divided clock out.
// R12: Auto bit selects single-byte mode or automatic multi-byte mode.
// R13: First-bit select 0 sends MSB first, 1 sends LSB first; auto mode still sends RAM bytes MSB first.
// R14: Bit reversal acts on register write and read, shift direction fixed.
// R15: Shift and drive next serial out bit on serial clock falling edge.
// R16: Sample serial in on serial clock rising edge.
// R17: After eight bits stop shifting and set transfer done flag.
// R18: Writing the shift register forces serial out low.
// R19: Write starts transfer only if enabled and clock idle or high.
// R20: Enabling after writing data starts no transfer.
// R21: With partner clock, software clears strobe and busy enables.
// R22: Auto mode moves up to 32 bytes via on-chip RAM with strobe/busy.
module tws_channel (
  input  wire logic                 ref_clk,        // System clock, 100 MHz
  input  wire logic                 rst,            // Synchronous reset, high
  input  wire logic                 clkEn,          // Freezes all state when low
  input  wire logic [17:0]          avs_address,    // Byte address
  input  wire logic                 avs_read,       // Read request
  input  wire logic                 avs_write,      // Write request
  input  wire logic [31:0]          avs_writedata,  // Write data
  input  wire logic [3:0]           avs_byteenable, // Byte lanes
  output logic      [31:0]          avs_readdata,   // Read data
  output logic                      avs_waitrequest,// Stall
  input  wire tws_pkg::tws_pin_in_s pinIn,          // Pins from partner
  output tws_pkg::tws_pin_out_s     pinOut          // Pins to partner
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [7:0] revBits(input logic [7:0] v);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction

  function automatic logic [15:0] wordIdx(input logic [17:0] a);
    return a[17:2];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0]  modeQ;
  logic [7:0]  gapQ;
  logic [7:0]  divQ;
  logic [2:0]  autoQ;
  logic [4:0]  countQ;
  logic [4:0]  ptrQ;
  logic [7:0]  shQ;
  logic [2:0]  bitCntQ;
  logic        activeQ;
  logic        doneQ;
  logic        soQ;
  logic        sckIntQ;
  logic [7:0]  halfCntQ;
  logic        stbQ;
  logic [11:0] gapCntQ;
  logic        ackQ;
  logic [7:0]  ram [`TWS_RAM_WORDS];
  tws_pkg::tws_state_e stateQ;
  logic [1:0]  sckSyncQ;
  logic        sckPrevQ;
  logic [1:0]  siSyncQ;
  logic [1:0]  busySyncQ;

  logic        chanEn;
  logic        lsbFirst;
  logic        autoMode;
  logic        intClk;
  logic        gapEn;
  logic [15:0] idx;
  logic        wrAcc;
  logic        rdAcc;
  logic        wrMode;
  logic        wrGap;
  logic        wrData;
  logic        wrStatus;
  logic        wrAuto;
  logic        isRam;
  logic        sckFall;
  logic        sckRise;
  logic        byteEnd;
  logic        canStart;
  logic        startPlain;
  logic        startAuto;
  logic [11:0] gapLen;
  logic [11:0] twoSck;
  logic [11:0] gapTarget;
  logic [7:0]  rdVal;

  assign chanEn   = modeQ[`TWS_MODE_EN];
  assign lsbFirst = modeQ[`TWS_MODE_LSB];                           // R13
  assign autoMode = modeQ[`TWS_MODE_AUTO];
  assign intClk   = modeQ[`TWS_MODE_CLKSEL];
  assign gapEn    = gapQ[`TWS_GAP_EN];

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait state on every access
  assign idx      = wordIdx(avs_address);
  assign wrAcc    = avs_write & ackQ & clkEn;
  assign rdAcc    = avs_read & ~ackQ;
  assign wrMode   = wrAcc & avs_byteenable[0] & (idx == `TWS_IDX_MODE);
  assign wrGap    = wrAcc & avs_byteenable[0] & (idx == `TWS_IDX_GAP);
  assign wrData   = wrAcc & avs_byteenable[0] & (idx == `TWS_IDX_DATA);
  assign wrStatus = wrAcc & avs_byteenable[0] & (idx == `TWS_IDX_STATUS);
  assign wrAuto   = wrAcc & avs_byteenable[0] & (idx == `TWS_IDX_AUTO);
  assign isRam    = (idx >= `TWS_IDX_RAM) && (idx < (`TWS_IDX_RAM + 16'(`TWS_RAM_WORDS)));
  assign avs_waitrequest = (avs_read | avs_write) & ~(ackQ & clkEn);

  // Ack pulses for one cycle, so each request ends at the second edge
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ackQ <= 1'b0;
    end else if (clkEn) begin
      ackQ <= (avs_read | avs_write) & ~ackQ;
    end
  end

  // Read decode; unmapped words read as zero
  always_comb begin
    rdVal = 8'h00;
    if (idx == `TWS_IDX_MODE) begin
      rdVal = modeQ;
    end else if (idx == `TWS_IDX_GAP) begin
      rdVal = gapQ;
    end else if (idx == `TWS_IDX_DATA) begin
      rdVal = lsbFirst ? revBits(shQ) : shQ;                       // R14
    end else if (idx == `TWS_IDX_STATUS) begin
      rdVal = {5'h00, stateQ != tws_pkg::ST_IDLE, activeQ, doneQ};
    end else if (idx == `TWS_IDX_DIV) begin
      rdVal = divQ;
    end else if (idx == `TWS_IDX_AUTO) begin
      rdVal = {5'h00, autoQ[2:1], 1'b0};
    end else if (idx == `TWS_IDX_COUNT) begin
      rdVal = {3'h0, countQ};
    end else if (isRam) begin
      rdVal = ram[idx[4:0]];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (clkEn && rdAcc) begin
      avs_readdata <= {24'h00_0000, rdVal};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  // Fixed bits of the mode register always read back at their tied levels
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      modeQ  <= `TWS_MODE_RST;
      gapQ   <= `TWS_GAP_RST;
      divQ   <= `TWS_DIV_RST;
      autoQ  <= 3'h0;
      countQ <= 5'h00;
    end else if (clkEn) begin
      if (wrMode) begin
        modeQ <= {avs_writedata[7:5], 3'h0, avs_writedata[1], 1'b1};
      end
      if (wrGap) begin
        gapQ <= {avs_writedata[7], 2'h0, avs_writedata[4:0]};      // R6
      end
      if (wrAcc && avs_byteenable[0] && idx == `TWS_IDX_DIV) begin
        divQ <= (avs_writedata[7:0] == 8'h00) ? 8'h01 : avs_writedata[7:0];
      end
      if (wrAcc && avs_byteenable[0] && idx == `TWS_IDX_COUNT) begin
        countQ <= avs_writedata[4:0];
      end
      if (wrAuto) begin
        autoQ <= avs_writedata[2:0];
      end else if (startAuto) begin
        autoQ[`TWS_AUTO_START] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sckSyncQ  <= 2'b11;
      sckPrevQ  <= 1'b1;
      siSyncQ   <= 2'b00;
      busySyncQ <= 2'b00;
    end else if (clkEn) begin
      sckSyncQ  <= {sckSyncQ[0], pinIn.sckIn};
      sckPrevQ  <= sckSyncQ[1];
      siSyncQ   <= {siSyncQ[0], pinIn.siIn};
      busySyncQ <= {busySyncQ[0], pinIn.busyIn};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Internal serial clock: idles high, runs only while a byte moves
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sckIntQ  <= 1'b1;
      halfCntQ <= 8'h00;
    end else if (clkEn) begin
      if (!activeQ || !intClk) begin
        sckIntQ  <= 1'b1;
        halfCntQ <= 8'h00;
      end else if (halfCntQ == divQ - 8'h01) begin
        halfCntQ <= 8'h00;
        sckIntQ  <= ~sckIntQ;
      end else begin
        halfCntQ <= halfCntQ + 8'h01;
      end
    end
  end

  // Edge source picked by the clock source bit
  always_comb begin
    if (intClk) begin                                              // R11
      sckFall = activeQ && sckIntQ && (halfCntQ == divQ - 8'h01);
      sckRise = activeQ && !sckIntQ && (halfCntQ == divQ - 8'h01);
    end else begin
      sckFall = activeQ && sckPrevQ && !sckSyncQ[1];
      sckRise = activeQ && !sckPrevQ && sckSyncQ[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer start and end
  // A partner clock held low means the previous byte is not yet closed
  assign canStart   = chanEn && !activeQ && (intClk || sckSyncQ[1]);  // R19
  assign startPlain = wrData && !autoMode && canStart;               // R20
  assign startAuto  = chanEn && autoMode && autoQ[`TWS_AUTO_START]
                      && stateQ == tws_pkg::ST_IDLE;                  // R12
  assign byteEnd    = sckRise && (bitCntQ == 3'h7);                  // R17

  ////////////////////////////////////////////////////////////////////////////
  // Shift register and bit counter
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      shQ     <= 8'h00;
      soQ     <= 1'b0;
      bitCntQ <= 3'h0;
      activeQ <= 1'b0;
    end else if (clkEn) begin
      if (!chanEn) begin
        activeQ <= 1'b0;                                           // R10
        bitCntQ <= 3'h0;                                           // R10
        if (wrData) begin
          shQ <= lsbFirst ? revBits(avs_writedata[7:0]) : avs_writedata[7:0]; // R8
          soQ <= 1'b0;                                             // R18
        end
      end else if (wrData && !activeQ) begin
        shQ     <= lsbFirst ? revBits(avs_writedata[7:0]) : avs_writedata[7:0]; // R14
        soQ     <= 1'b0;                                           // R18
        bitCntQ <= 3'h0;
        activeQ <= startPlain;                                     // R19
      end else if (stateQ == tws_pkg::ST_LOAD) begin
        shQ     <= ram[ptrQ];                                      // R22
        soQ     <= 1'b0;
        bitCntQ <= 3'h0;
        activeQ <= 1'b1;
      end else begin
        if (sckFall) begin
          soQ <= shQ[7];                                           // R15
        end
        if (sckRise) begin
          shQ     <= {shQ[6:0], siSyncQ[1]};                       // R16
          bitCntQ <= bitCntQ + 3'h1;                               // R10
          if (bitCntQ == 3'h7) begin
            activeQ <= 1'b0;                                       // R17
          end
        end
      end
    end
  end

  // Done flag: the set wins over a write-one clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      doneQ <= 1'b0;
    end else if (clkEn) begin
      if (byteEnd) begin
        doneQ <= 1'b1;                                             // R17
      end else if (wrStatus && avs_writedata[`TWS_ST_DONE]) begin
        doneQ <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buffer RAM: software writes it, received bytes overwrite it in place
  always_ff @(posedge ref_clk) begin
    if (clkEn) begin
      if (stateQ == tws_pkg::ST_SHIFT && byteEnd) begin
        ram[ptrQ] <= {shQ[6:0], siSyncQ[1]};                       // R22
      end else if (wrAcc && avs_byteenable[0] && isRam) begin
        ram[idx[4:0]] <= avs_writedata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Inter-byte gap length
  // Midpoint of the 28..36 window; the wait for the next falling edge
  // adds the half to one and a half serial clocks on top
  assign gapLen    = (12'({7'h00, gapQ[4:0]}) + 12'h001) * 12'(`TWS_GAP_UNIT)
                     + 12'(`TWS_GAP_FIX);                           // R2 R3
  assign twoSck    = 12'({divQ, 2'b00}) * 12'(`TWS_GAP_MIN_SCK / 2);
  assign gapTarget = (gapLen < twoSck) ? twoSck : gapLen;           // R4

  ////////////////////////////////////////////////////////////////////////////
  // Automatic multi-byte sequencer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stateQ  <= tws_pkg::ST_IDLE;
      ptrQ    <= 5'h00;
      gapCntQ <= 12'h000;
      stbQ    <= 1'b0;
    end else if (clkEn) begin
      if (!chanEn || !autoMode) begin
        stateQ <= tws_pkg::ST_IDLE;
        stbQ   <= 1'b0;
      end else begin
        case (stateQ)
          tws_pkg::ST_IDLE: begin
            if (startAuto) begin
              ptrQ   <= countQ;
              stateQ <= tws_pkg::ST_LOAD;
            end
          end
          tws_pkg::ST_LOAD: begin
            stateQ <= tws_pkg::ST_SHIFT;
          end
          tws_pkg::ST_SHIFT: begin
            if (byteEnd) begin
              stbQ   <= autoQ[`TWS_AUTO_STBEN];
              stateQ <= tws_pkg::ST_STROBE;
            end
          end
          tws_pkg::ST_STROBE: begin
            stbQ    <= 1'b0;
            gapCntQ <= 12'h000;
            if (ptrQ == 5'h00) begin
              stateQ <= tws_pkg::ST_IDLE;
            end else begin
              ptrQ   <= ptrQ - 5'h01;
              stateQ <= gapEn ? tws_pkg::ST_GAP : tws_pkg::ST_BUSY; // R1
            end
          end
          tws_pkg::ST_GAP: begin
            // Busy input is not looked at while the gap timer rules
            if (gapCntQ >= gapTarget - 12'h001) begin               // R7
              stateQ <= tws_pkg::ST_LOAD;
            end else begin
              gapCntQ <= gapCntQ + 12'h001;                          // R1
            end
          end
          tws_pkg::ST_BUSY: begin
            if (!(autoQ[`TWS_AUTO_BUSYEN] && busySyncQ[1])) begin
              stateQ <= tws_pkg::ST_LOAD;
            end
          end
          default: begin
            stateQ <= tws_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers; in stop mode every pin is released to the port logic
  always_comb begin
    pinOut.portMode = !chanEn;                                     // R9
    pinOut.sckOut   = sckIntQ;
    pinOut.sckOe    = chanEn && intClk;                            // R11
    pinOut.soOut    = soQ;
    pinOut.soOe     = chanEn;                                      // R9
    pinOut.stbOut   = stbQ;
    pinOut.stbOe    = chanEn && autoQ[`TWS_AUTO_STBEN];
  end

endmodule

// ===== tws_regs.svh
`ifndef TWS_REGS_SVH
`define TWS_REGS_SVH
// Register indices; byte address on the bus is four times the index
`define TWS_IDX_MODE      16'hff68
`define TWS_IDX_GAP       16'hff6b
`define TWS_IDX_DATA      16'hff6c
`define TWS_IDX_STATUS    16'hff6d
`define TWS_IDX_DIV       16'hff6e
`define TWS_IDX_AUTO      16'hff6f
`define TWS_IDX_COUNT     16'hff70
`define TWS_IDX_RAM       16'hffa0
`define TWS_RAM_WORDS     32
// Reset values
`define TWS_MODE_RST      8'h01
`define TWS_GAP_RST       8'h00
`define TWS_DIV_RST       8'h08
// Mode register fields
`define TWS_MODE_EN       7
`define TWS_MODE_LSB      6
`define TWS_MODE_AUTO     5
`define TWS_MODE_CLKSEL   1
`define TWS_MODE_FIXED    0
// Gap register fields
`define TWS_GAP_EN        7
`define TWS_GAP_CNT_W     5
// Auto control fields
`define TWS_AUTO_START    0
`define TWS_AUTO_BUSYEN   1
`define TWS_AUTO_STBEN    2
// Status fields
`define TWS_ST_DONE       0
`define TWS_ST_ACTIVE     1
`define TWS_ST_AUTO       2
// Gap timing in system clocks: (n+1)*64 plus a fixed part
`define TWS_GAP_UNIT      64
`define TWS_GAP_MIN_FIX   28
`define TWS_GAP_MAX_FIX   36
`define TWS_GAP_FIX       32
`define TWS_GAP_MIN_SCK   2
`endif

// ===== tws_pkg.sv
package tws_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_LOAD  = 3'b001,
    ST_SHIFT = 3'b010,
    ST_STROBE = 3'b011,
    ST_GAP   = 3'b100,
    ST_BUSY  = 3'b101
  } tws_state_e;

  // Pin-side inputs of the channel
  typedef struct packed {
    logic sckIn;
    logic siIn;
    logic busyIn;
  } tws_pin_in_s;

  // Pin-side outputs of the channel
  typedef struct packed {
    logic sckOut;
    logic sckOe;
    logic soOut;
    logic soOe;
    logic stbOut;
    logic stbOe;
    logic portMode;
  } tws_pin_out_s;
endpackage

// ===== tws_channel_checker.sv
`include "tws_regs.svh"
module tws_channel_checker (
  input wire logic                  ref_clk,         // Clock
  input wire logic                  rst,             // Reset
  input wire logic [17:0]           avs_address,     // Address
  input wire logic                  avs_read,        // Read
  input wire logic                  avs_write,       // Write
  input wire logic [31:0]           avs_readdata,    // Read data
  input wire logic                  avs_waitrequest, // Stall
  input wire tws_pkg::tws_pin_out_s pinOut           // Pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic dataWr;
  // Data writes land where the stall drops
  assign dataWr = avs_write && !avs_waitrequest && avs_address == {`TWS_IDX_DATA, 2'b00};
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  sequence s_req;
    $rose(avs_read || avs_write) ##0 avs_waitrequest;
  endsequence
  sequence s_ack;
    !avs_waitrequest;
  endsequence
  property p_one_wait;
    s_req |=> s_ack;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("bus answer not after one wait");
  property p_rd_hi;
    avs_readdata[31:8] == 24'h000000;
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("upper read lanes not zero");
  property p_stop_pins;
    pinOut.portMode |-> !(pinOut.soOe || pinOut.sckOe || pinOut.stbOe);
  endproperty
  a_stop_pins: assert property (p_stop_pins) else $error("pin driven in stop mode");
  property p_stop_quiet;
    pinOut.portMode |-> pinOut.sckOut && !pinOut.stbOut;
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("clock moved in stop mode");
  property p_sck_dir;
    pinOut.sckOe |-> pinOut.soOe && !pinOut.portMode;
  endproperty
  a_sck_dir: assert property (p_sck_dir) else $error("clock driven while off");
  // Data may follow the falling edge by one cycle, never later
  property p_so_fall;
    pinOut.sckOe && $past(pinOut.sckOe) && !$past(pinOut.sckOut, 2) && !$past(pinOut.sckOut)
      |-> $stable(pinOut.soOut);
  endproperty
  a_so_fall: assert property (p_so_fall) else $error("data moved off falling edge");
  property p_wr_low;
    dataWr |=> !pinOut.soOut;
  endproperty
  a_wr_low: assert property (p_wr_low) else $error("data write left output high");
  property p_stb_pulse;
    pinOut.stbOut |-> pinOut.stbOe ##1 !pinOut.stbOut;
  endproperty
  a_stb_pulse: assert property (p_stb_pulse) else $error("strobe not one cycle");
endmodule

bind tws_channel tws_channel_checker u_chk (
  .ref_clk,
  .rst,
  .avs_address,
  .avs_read,
  .avs_write,
  .avs_readdata,
  .avs_waitrequest,
  .pinOut
);

// ===== tws_partner.sv
module tws_partner (
  input  wire logic       ref_clk, // System clock
  input  wire logic       rst,     // Reset
  input  wire logic       sckLine, // Serial clock wire
  input  wire logic       soLine,  // Data from device
  input  wire logic       extGo,   // Clock out one byte
  input  wire logic [7:0] txByte,  // Byte to send
  input  wire logic [7:0] half,    // Own half period
  output logic            sckDrv,  // Own clock drive
  output logic            siOut,   // Data to device
  output logic            gotV,    // Byte taken
  output logic [7:0]      rxByte   // Last byte taken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       sckQ;
  logic [7:0] txQ;
  logic [7:0] tick;
  logic [3:0] bitN;
  logic [4:0] edgeN;
  ////////////////////////////////////////
  // Own clock stands high outside a frame; sixteen edges a byte
  always_ff @(posedge ref_clk) begin
    if (rst || extGo) begin
      sckDrv <= 1'b1;
      edgeN  <= {extGo, 4'h0};
      tick   <= 8'h00;
    end else if (edgeN != 5'h00) begin
      tick <= (tick == half - 8'h01) ? 8'h00 : tick + 8'h01;
      if (tick == half - 8'h01) begin
        sckDrv <= !sckDrv;
        edgeN  <= edgeN - 5'h01;
      end
    end
  end
  ////////////////////////////////////////
  // Between frames the data line toggles so a stale bit is never mistaken for data
  always_ff @(posedge ref_clk) begin
    sckQ <= sckLine;
    gotV <= 1'b0;
    if (rst) begin
      bitN  <= 4'h8;
      siOut <= 1'b0;
    end else if (sckQ && !sckLine) begin
      siOut <= (bitN == 4'h8) ? txByte[7] : txQ[7];
      txQ   <= (bitN == 4'h8) ? {txByte[6:0], 1'b0} : {txQ[6:0], 1'b0};
      if (bitN == 4'h8) bitN <= 4'h0;
    end else if (!sckQ && sckLine) begin
      rxByte <= {rxByte[6:0], soLine};
      bitN   <= bitN + 4'h1;
      gotV   <= (bitN == 4'h7);
    end else if (bitN == 4'h8) begin
      siOut <= !siOut;
    end
  end
endmodule

// ===== tb_top.sv
`include "tws_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst, avsRead, avsWrite, waitReq, extGo, busy, sckDrv, siOut, gotV, sckWas;
  logic [17:0]           avsAddr;
  logic [31:0]           avsWdata, avsRdata, seed;
  logic [7:0]            txByte, rxByte;
  logic [7:0]            rxQ[$];
  int                    gapQ[$];
  int                    failures, samplesChecked, cyc, riseN, lastRise;
  tws_pkg::tws_pin_in_s  pinIn;
  tws_pkg::tws_pin_out_s pinOut;
  wire                   sckLine = pinOut.sckOe ? pinOut.sckOut : sckDrv;
  assign pinIn = {sckLine, siOut, busy};
  tws_channel DUT (.ref_clk, .rst, .clkEn(1'b1), .avs_address(avsAddr), .avs_read(avsRead),
    .avs_write(avsWrite), .avs_writedata(avsWdata), .avs_byteenable(4'h1),
    .avs_readdata(avsRdata), .avs_waitrequest(waitReq), .pinIn, .pinOut);
  tws_partner u_far (.ref_clk, .rst, .sckLine, .soLine(pinOut.soOut), .extGo, .txByte,
    .half(8'h08), .sckDrv, .siOut, .gotV, .rxByte);
  ////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = !ref_clk;
  end
  // Stamps clock edges so inter-byte gaps are timed from the wire
  always @(posedge ref_clk) begin
    cyc++;
    sckWas <= pinOut.sckOut;
    if (pinOut.sckOut && !sckWas) begin
      riseN++;
      lastRise = cyc;
    end
    if (!pinOut.sckOut && sckWas && riseN > 0 && riseN % 8 == 0) gapQ.push_back(cyc - lastRise);
    if (gotV) rxQ.push_back(rxByte);
  end
  ////////////////////////////////////////
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic logic [7:0] rev(logic [7:0] v);
    for (int i = 0; i < 8; i++) rev[i] = v[7-i];
  endfunction
  task automatic chk(string what, logic [15:0] e, logic [15:0] g);
    samplesChecked++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  // Holds the request until the stall drops; one idle edge always follows
  task automatic bus(logic w, logic [15:0] idx, logic [7:0] d, output logic [7:0] q);
    @(posedge ref_clk);
    avsRead <= !w;
    avsWrite <= w;
    avsAddr <= {idx, 2'b00};
    avsWdata <= {24'h000000, d};
    // No cycle count is assumed: only the watchdog ends a stalled access
    do begin
      @(posedge ref_clk);
    end while (waitReq !== 1'b0);
    q = avsRdata[7:0];
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask
  task automatic wr(logic [15:0] a, logic [7:0] d);
    logic [7:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rdc(string s, logic [15:0] a, logic [7:0] e);
    logic [7:0] x;
    bus(1'b0, a, 8'h00, x);
    chk(s, e, x);
  endtask
  task automatic xfer(logic [7:0] m, logic [7:0] tx, logic [7:0] rx);
    logic [7:0] q;
    wr(`TWS_IDX_MODE, m);
    txByte <= rx;
    wr(`TWS_IDX_DATA, tx);
    chk("sck drive", m[1], pinOut.sckOe);
    if (!m[1]) begin
      extGo <= 1'b1;
      @(posedge ref_clk);
      extGo <= 1'b0;
    end
    q = 8'h00;
    for (int i = 0; i < 400 && !q[0]; i++) bus(1'b0, `TWS_IDX_STATUS, 8'h00, q);
    wr(`TWS_IDX_STATUS, 8'h01);
    chk("wire byte", m[6] ? rev(tx) : tx, rxByte);
    bus(1'b0, `TWS_IDX_DATA, 8'h00, q);
    chk("read byte", m[6] ? rev(rx) : rx, q);
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge ref_clk);
    failures++;
    wrap_up();
  end
  ////////////////////////////////////////
  initial begin
    logic [7:0] d, s;
    logic [7:0] ram[3];
    int n, dv, lo, hi;
    {rst, avsRead, avsWrite, extGo, busy} = 5'h10;
    {avsAddr, avsWdata, txByte} = '0;
    seed = 32'h0000001f;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    rdc("mode reset", `TWS_IDX_MODE, 8'h01);
    rdc("gap reset", `TWS_IDX_GAP, 8'h00);
    rdc("unmapped", 16'hff71, 8'h00);
    wr(`TWS_IDX_DIV, 8'h04);
    wr(`TWS_IDX_AUTO, 8'h00);
    // Stop mode first: data only stored, enabling later must not start it
    wr(`TWS_IDX_MODE, 8'h02);
    rdc("mode fixed bit", `TWS_IDX_MODE, 8'h03);
    d = xs();
    wr(`TWS_IDX_DATA, d);
    chk("port mode", 1'b1, pinOut.portMode);
    wr(`TWS_IDX_MODE, 8'h82);
    rdc("late enable", `TWS_IDX_STATUS, 8'h00);
    rdc("stop data", `TWS_IDX_DATA, d);
    for (int i = 0; i < 8; i++) xfer({1'b1, i[0], 4'h0, !i[1], 1'b0}, xs(), xs());
    // Automatic runs: busy held asserted, which the gap control must ignore
    for (int k = 0; k < 2; k++) begin
      n = k ? 0 : xs() % 4;
      dv = k ? 40 : 4;
      wr(`TWS_IDX_DIV, dv[7:0]);
      wr(`TWS_IDX_GAP, 8'h80 | n[7:0]);
      for (int j = 0; j < 3; j++) begin
        ram[j] = xs();
        wr(`TWS_IDX_RAM + j, ram[j]);
      end
      wr(`TWS_IDX_COUNT, 8'h02);
      wr(`TWS_IDX_MODE, 8'ha2);
      busy <= 1'b1;
      gapQ.delete();
      rxQ.delete();
      riseN = 0;
      wr(`TWS_IDX_AUTO, 8'h07);
      s = 8'h04;
      for (int i = 0; i < 3000 && s[2]; i++) bus(1'b0, `TWS_IDX_STATUS, 8'h00, s);
      chk("auto count", 3, rxQ.size());
      for (int j = 0; j < 3 && j < rxQ.size(); j++) chk("auto byte", ram[2-j], rxQ[j]);
      lo = (n + 1) * 64 + 28 + dv;
      if (lo < 4 * dv) lo = 4 * dv;
      hi = (n + 1) * 64 + 36 + 3 * dv;
      chk("gap count", 2, gapQ.size());
      foreach (gapQ[j]) chk("gap", gapQ[j] < lo ? lo : gapQ[j] > hi ? hi : gapQ[j], gapQ[j]);
      busy <= 1'b0;
      wr(`TWS_IDX_STATUS, 8'h01);
    end
    wrap_up();
  end
endmodule
